// ===== timer_pair_pkg.sv
/*
  package for the paired timer control bank: register indices, field
  positions, reset values, timing counts and the control field struct.
  assumes the register indices are word indices on apb (byte address = 4 x index).
*/
package timer_pair_pkg;
  // register indices; byte address is four times the index
  localparam logic [15:0] IDX_CH1_COUNT = 16'hff37;
  localparam logic [15:0] IDX_CH2_CTRL = 16'hff38;
  localparam logic [15:0] IDX_CH3_CTRL = 16'hff39;
  localparam logic [15:0] IDX_CH2_RELOAD = 16'hff3a;
  localparam logic [15:0] IDX_CH3_RELOAD = 16'hff3b;
  localparam logic [15:0] IDX_CH2_COMPARE = 16'hff3c;
  // control register bit positions
  localparam int BIT_MODE16 = 7;
  localparam int BIT_NR_EN = 6;
  localparam int BIT_INV_OUT = 4;
  localparam int BIT_CLK_OUT = 3;
  localparam int BIT_RUN = 2;
  localparam int BIT_PRESET = 1;
  localparam int BIT_CKSEL = 0;
  // reset values
  localparam logic [7:0] RST_RELOAD = 8'hff;
  localparam logic [7:0] RST_COMPARE = 8'h00;
  localparam logic [7:0] RST_COUNT = 8'hff;
  // timing: internal count clock period and noise rejector hold time
  localparam int CLK_PERIOD_NS = 25;
  localparam int INT_TICK_NS = 100;
  localparam int INT_DIV = (INT_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int NR_HOLD_NS = 75;
  localparam int NR_CYCLES = (NR_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // per channel control fields
  typedef struct packed {
    logic inv_out;
    logic clk_out;
    logic run;
    logic cksel;
  } chan_ctrl_t;
  // apb bus phase encoding, not used by the bank
  typedef enum logic [0:0] {
    BUS_IDLE = 1'b0,
    BUS_ACCESS = 1'b1
  } bus_phase_t;
endpackage

// ===== paired_timer_control_bank.sv
/*
  paired timer control bank: apb register slice for timer channels two and
  three with 8/16-bit chaining, external clock noise rejector, run, preset
  and normal / inverted clock outputs.
  assumes one 40 MHz pclk, async active-low presetn, apb master, and an
  external clock pin that is asynchronous to pclk.
*/
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps
// Function
// R1: mode bit chains channels two, three
// R2: noise rejector on external clock one
// R3: channel two inverted clock output enable
// R4: channel three inverted clock output enable
// R5: channel two clock output enable
// R6: channel three clock output enable
// R7: channel two clock source select
// R8: channel three clock source select
// R9: channel two reload value, resets ones
// R10: channel three reload value, resets ones
// R11: channel two compare value, resets zero
// R12: run halts counting, preset loads reload
// R13: channel one count read-only, unused zero
module paired_timer_control_bank
  import timer_pair_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ext_clk1,
  input wire logic [7:0] ch1_count_value,
  output logic ch2_clk_out,
  output logic ch2_inv_clk_out,
  output logic ch3_clk_out,
  output logic ch3_inv_clk_out
);
  // register state
  logic mode16; // chain two and three
  logic nr_en; // noise rejector enable
  chan_ctrl_t ch2; // channel two control fields
  chan_ctrl_t ch3; // channel three control fields
  logic [7:0] ch2_reload_value;
  logic [7:0] ch3_reload_value;
  logic [7:0] ch2_compare_value;
  logic [7:0] ch1_snap; // channel one count capture
  logic [7:0] cnt2; // channel two counter
  logic [7:0] cnt3; // channel three counter
  logic tout2; // channel two toggle clock
  logic tout3; // channel three toggle clock
  // external clock synchroniser and filter
  logic ext_meta;
  logic ext_sync;
  logic ext_filt;
  logic ext_prev;
  logic [7:0] nr_cnt;
  // internal clock divider
  logic [7:0] div_cnt;

  // bus decode
  wire logic setup = psel & ~penable;
  wire logic wr_en = psel & penable & pready & pwrite;
  wire logic hit_ch1 = paddr == {14'h0000, IDX_CH1_COUNT, 2'b00};
  wire logic hit_ch2c = paddr == {14'h0000, IDX_CH2_CTRL, 2'b00};
  wire logic hit_ch3c = paddr == {14'h0000, IDX_CH3_CTRL, 2'b00};
  wire logic hit_ch2r = paddr == {14'h0000, IDX_CH2_RELOAD, 2'b00};
  wire logic hit_ch3r = paddr == {14'h0000, IDX_CH3_RELOAD, 2'b00};
  wire logic hit_ch2m = paddr == {14'h0000, IDX_CH2_COMPARE, 2'b00};
  wire logic hit_any = hit_ch1 | hit_ch2c | hit_ch3c | hit_ch2r | hit_ch3r | hit_ch2m;
  // preset strobes, one cycle, never stored
  wire logic preset2 = wr_en & hit_ch2c & pwdata[BIT_PRESET]; // R12
  wire logic preset3 = wr_en & hit_ch3c & pwdata[BIT_PRESET]; // R12

  // read views; preset and unused bits read zero
  wire logic [7:0] rd_ch2c = {mode16, nr_en, 1'b0, ch2.inv_out, ch2.clk_out, ch2.run,
                              1'b0, ch2.cksel}; // R13
  wire logic [7:0] rd_ch3c = {3'b000, ch3.inv_out, ch3.clk_out, ch3.run,
                              1'b0, ch3.cksel}; // R13
  logic [7:0] rd_byte;
  // address decode to read byte
  always_comb begin
    if (hit_ch1) begin
      rd_byte = ch1_snap; // R13
    end else if (hit_ch2c) begin
      rd_byte = rd_ch2c;
    end else if (hit_ch3c) begin
      rd_byte = rd_ch3c;
    end else if (hit_ch2r) begin
      rd_byte = ch2_reload_value;
    end else if (hit_ch3r) begin
      rd_byte = ch3_reload_value;
    end else if (hit_ch2m) begin
      rd_byte = ch2_compare_value;
    end else begin
      rd_byte = 8'h00;
    end
  end

  // apb answer: one wait-free access phase, data latched at setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      if (setup) begin
        prdata <= {24'h00_0000, rd_byte};
        pslverr <= ~hit_any;
      end
    end
  end

  // control registers; writes take effect at the access edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode16 <= 1'b0; // R1
      nr_en <= 1'b0; // R2
      ch2 <= '0; // R3 R5 R7
      ch3 <= '0; // R4 R6 R8
    end else if (wr_en && hit_ch2c) begin
      mode16 <= pwdata[BIT_MODE16]; // R1
      nr_en <= pwdata[BIT_NR_EN]; // R2
      ch2 <= {pwdata[BIT_INV_OUT], pwdata[BIT_CLK_OUT], pwdata[BIT_RUN],
              pwdata[BIT_CKSEL]}; // R3 R5 R7
    end else if (wr_en && hit_ch3c) begin
      ch3 <= {pwdata[BIT_INV_OUT], pwdata[BIT_CLK_OUT], pwdata[BIT_RUN],
              pwdata[BIT_CKSEL]}; // R4 R6 R8
    end
  end

  // data registers: reload and compare values
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ch2_reload_value <= RST_RELOAD; // R9
      ch3_reload_value <= RST_RELOAD; // R10
      ch2_compare_value <= RST_COMPARE; // R11
    end else if (wr_en) begin
      if (hit_ch2r) begin
        ch2_reload_value <= pwdata[7:0]; // R9
      end
      if (hit_ch3r) begin
        ch3_reload_value <= pwdata[7:0]; // R10
      end
      if (hit_ch2m) begin
        ch2_compare_value <= pwdata[7:0]; // R11
      end
    end
  end

  // channel one count capture; software cannot write it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ch1_snap <= RST_COUNT; // R13
    end else begin
      ch1_snap <= ch1_count_value;
    end
  end

  // internal count clock: one-cycle enable every INT_DIV cycles
  wire logic int_tick = div_cnt == 8'(INT_DIV - 1);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt <= 8'h00;
    end else begin
      div_cnt <= int_tick ? 8'h00 : div_cnt + 8'h01;
    end
  end

  // external clock pin: two-flop synchroniser
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_meta <= 1'b0;
      ext_sync <= 1'b0;
    end else begin
      ext_meta <= ext_clk1;
      ext_sync <= ext_meta;
    end
  end

  // noise rejector: new level accepted only after NR_CYCLES stable samples
  wire logic nr_settle = nr_cnt == 8'(NR_CYCLES - 1);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nr_cnt <= 8'h00;
      ext_filt <= 1'b0;
    end else if (ext_sync == ext_filt) begin
      nr_cnt <= 8'h00;
    end else if (nr_settle) begin
      nr_cnt <= 8'h00;
      ext_filt <= ext_sync; // R2
    end else begin
      nr_cnt <= nr_cnt + 8'h01;
    end
  end

  // filtered or raw level, rising edge gives the external count tick
  wire logic ext_level = nr_en ? ext_filt : ext_sync; // R2
  wire logic ext_tick = ext_level & ~ext_prev;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_prev <= 1'b0;
    end else begin
      ext_prev <= ext_level;
    end
  end

  // count enables; in 16-bit mode channel three counts channel two underflows
  wire logic src2 = ch2.cksel ? ext_tick : int_tick; // R7
  wire logic src3 = ch3.cksel ? ext_tick : int_tick; // R8
  wire logic tick2 = ch2.run & src2; // R12
  wire logic under2 = tick2 & (cnt2 == 8'h00);
  wire logic tick3 = ch3.run & (mode16 ? under2 : src3); // R1 R12
  wire logic under3 = tick3 & (cnt3 == 8'h00);
  wire logic match2 = tick2 & (cnt2 == ch2_compare_value);

  // channel two down counter with reload
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt2 <= RST_COUNT;
    end else if (preset2 || under2) begin
      cnt2 <= ch2_reload_value; // R12
    end else if (tick2) begin
      cnt2 <= cnt2 - 8'h01;
    end
  end

  // channel three down counter with reload
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt3 <= RST_COUNT;
    end else if (preset3 || under3) begin
      cnt3 <= ch3_reload_value; // R12
    end else if (tick3) begin
      cnt3 <= cnt3 - 8'h01;
    end
  end

  // timer clocks: two toggles on compare or underflow but not on both at once, three on underflow
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tout2 <= 1'b0;
      tout3 <= 1'b0;
    end else begin
      if (match2 ^ under2) begin
        tout2 <= ~tout2;
      end
      if (under3) begin
        tout3 <= ~tout3;
      end
    end
  end

  // gated pin outputs, each from a flip-flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ch2_clk_out <= 1'b0;
      ch2_inv_clk_out <= 1'b0;
      ch3_clk_out <= 1'b0;
      ch3_inv_clk_out <= 1'b0;
    end else begin
      ch2_clk_out <= ch2.clk_out & tout2; // R5
      ch2_inv_clk_out <= ch2.inv_out & ~tout2; // R3
      ch3_clk_out <= ch3.clk_out & tout3; // R6
      ch3_inv_clk_out <= ch3.inv_out & ~tout3; // R4
    end
  end

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  mode_write_a: assert property ( // R1
    wr_en && hit_ch2c |=> mode16 == $past(pwdata[BIT_MODE16]))
    else $error("mode bit did not follow write");
  chain_count_a: assert property ( // R1
    mode16 && ch3.run && !preset3 && cnt3 != 8'h00 && under2 |=> cnt3 == $past(cnt3) - 8'h01)
    else $error("chained channel three missed an underflow");
  filter_hold_a: assert property ( // R2
    $changed(ext_filt) |-> $past(ext_sync, 1) == ext_filt && $past(ext_sync, 2) == ext_filt)
    else $error("noise rejector passed a short pulse");
  inv2_off_a: assert property ( // R3
    !ch2.inv_out |=> !ch2_inv_clk_out)
    else $error("channel two inverted output not off");
  inv3_off_a: assert property ( // R4
    !ch3.inv_out |=> !ch3_inv_clk_out)
    else $error("channel three inverted output not off");
  out2_off_a: assert property ( // R5
    !ch2.clk_out |=> !ch2_clk_out)
    else $error("channel two clock output not off");
  out3_off_a: assert property ( // R6
    !ch3.clk_out |=> !ch3_clk_out)
    else $error("channel three clock output not off");
  src2_int_a: assert property ( // R7
    ch2.run && !ch2.cksel && int_tick && !preset2 && cnt2 != 8'h00
    |=> cnt2 == $past(cnt2) - 8'h01)
    else $error("channel two ignored internal clock");
  src3_ext_a: assert property ( // R8
    !mode16 && ch3.cksel && !ext_tick && !preset3 |=> cnt3 == $past(cnt3))
    else $error("channel three counted without external edge");
  reload_load_a: assert property ( // R9 R12
    preset2 |=> cnt2 == $past(ch2_reload_value))
    else $error("preset did not load reload value");
  compare_write_a: assert property ( // R11
    wr_en && hit_ch2m |=> ch2_compare_value == $past(pwdata[7:0]))
    else $error("compare value not written");
  run_halt_a: assert property ( // R12
    !ch2.run && !preset2 |=> $stable(cnt2))
    else $error("stopped channel two counted");
  ctrl_read_a: assert property ( // R12 R13
    setup && (hit_ch2c || hit_ch3c) |=> prdata[BIT_PRESET] == 1'b0 && prdata[31:8] == 24'h00_0000)
    else $error("control read showed preset or unused bits");
  ch1_read_a: assert property ( // R13
    setup && hit_ch1 |=> prdata[7:0] == $past(ch1_snap))
    else $error("channel one readout wrong");

  chain_under_c: cover property (mode16 && under2 ##1 under3);
  ext_count_c: cover property (ch2.run && ch2.cksel && ext_tick);
  preset_c: cover property (preset3);
  bad_addr_c: cover property (pready && pslverr);
endmodule

// ===== paired_timer_control_bank_bench.sv
/*
  bench for the paired timer control bank: apb master tasks, a register
  model and output watchers compared with the design.
  assumes the package constants and a wait-free apb slave.
*/
`timescale 1ns/1ps
module paired_timer_control_bank_bench;
  import timer_pair_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0000_0000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic ext_clk1 = 1'b0;
  logic [7:0] ch1_count_value = 8'hff;
  logic [31:0] prdata;
  logic pready, pslverr;
  logic ch2_clk_out, ch2_inv_clk_out, ch3_clk_out, ch3_inv_clk_out;
  int mismatches = 0;
  int cmp_count = 0;
  // register model and readable bits, index is offset from the first register
  logic [7:0] model [6] = '{8'hff, 8'h00, 8'h00, 8'hff, 8'hff, 8'h00};
  logic [7:0] rmask [6] = '{8'hff, 8'hdd, 8'h1d, 8'hff, 8'hff, 8'hff};
  int tog2 = 0;
  int tog3 = 0;
  int same2 = 0;
  int same3 = 0; // cycles with channel three outputs equal
  logic p2 = 1'b0;
  logic p3 = 1'b0;
  logic [31:0] q;
  logic e;
  paired_timer_control_bank i_paired_timer_control_bank (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .ext_clk1(ext_clk1),
    .ch1_count_value(ch1_count_value), .ch2_clk_out(ch2_clk_out),
    .ch2_inv_clk_out(ch2_inv_clk_out), .ch3_clk_out(ch3_clk_out),
    .ch3_inv_clk_out(ch3_inv_clk_out));
  // clock
  initial begin
    forever #12.5 pclk = ~pclk;
  end
  // output watchers, away from the sampling edge
  always @(negedge pclk) begin
    if (ch2_clk_out !== p2) tog2++;
    if (ch3_clk_out !== p3) tog3++;
    if (ch2_clk_out === ch2_inv_clk_out) same2++;
    if (ch3_clk_out === ch3_inv_clk_out) same3++;
    p2 = ch2_clk_out;
    p3 = ch3_clk_out;
  end
  task automatic test_done();
    if (mismatches == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // one apb transfer; held until pready is sampled high
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      mismatches++;
      $display("[ERR] pready expected 1 seen %b", pready);
      test_done();
    end
  endtask
  function automatic logic [31:0] adr(input int i);
    return {14'h0000, IDX_CH1_COUNT + 16'(i), 2'b00};
  endfunction
  task automatic wr(input int i, input logic [7:0] d);
    apb(1'b1, adr(i), {24'h00_0000, d});
    if (i > 0) model[i] = d & rmask[i];
  endtask
  task automatic rd(input int i);
    apb(1'b0, adr(i), 32'h0000_0000);
    chk("prdata", {24'h00_0000, model[i]}, q);
    chk("pslverr", 32'h0000_0000, 32'(e));
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // ext pin pulses: high for hi cycles, low for eight
  task automatic ext_run(input int hi);
    tog3 = 0;
    same3 = 0;
    repeat (20) begin
      ext_clk1 <= 1'b1;
      idle(hi);
      ext_clk1 <= 1'b0;
      idle(8);
    end
  endtask
  initial begin
    void'($urandom(32'h3d43d3ba));
    idle(10);
    presetn <= 1'b1;
    idle(2);
    q = 32'({ch2_clk_out, ch2_inv_clk_out, ch3_clk_out, ch3_inv_clk_out});
    chk("outs", 32'h0000_0000, q);
    for (int i = 0; i < 6; i++) rd(i);
    // unmapped place refuses
    apb(1'b1, 32'h0000_0100, 32'h0000_00ff);
    chk("wr_err", 32'h0000_0001, 32'(e));
    apb(1'b0, 32'h0000_0100, 32'h0000_0000);
    chk("rd_data", 32'h0000_0000, q);
    // random values, read-only and unused bits
    for (int r = 0; r < 4; r++) begin
      ch1_count_value <= 8'($urandom);
      for (int i = 0; i < 6; i++) wr(i, 8'($urandom));
      model[0] = ch1_count_value;
      for (int i = 0; i < 6; i++) rd(i);
    end
    // channel two on internal clock, both outputs
    wr(2, 8'h00);
    wr(3, 8'h02);
    // compare one inside the reload range, so match and underflow never coincide
    wr(5, 8'h01);
    wr(1, 8'h1e);
    idle(3);
    tog2 = 0;
    same2 = 0;
    idle(100);
    chk("ch2_tog", 32'h0000_0001, 32'(tog2 > 0));
    chk("ch2_pair", 32'h0000_0000, 32'(same2));
    wr(1, 8'h18);
    idle(3);
    tog2 = 0;
    idle(100);
    chk("ch2_stop", 32'h0000_0000, 32'(tog2));
    wr(1, 8'h00);
    idle(3);
    chk("ch2_off", 32'h0000_0000, 32'({ch2_clk_out, ch2_inv_clk_out}));
    // channel three on the external pin
    wr(4, 8'h01);
    wr(2, 8'h1f);
    idle(3);
    tog3 = 0;
    idle(100);
    chk("ch3_noext", 32'h0000_0000, 32'(tog3));
    ext_run(1);
    chk("ch3_raw", 32'h0000_0001, 32'(tog3 > 0));
    wr(1, 8'h40);
    ext_run(1);
    chk("ch3_glitch", 32'h0000_0000, 32'(tog3));
    ext_run(6);
    chk("ch3_filt", 32'h0000_0001, 32'(tog3 > 0));
    chk("ch3_pair", 32'h0000_0000, 32'(same3));
    wr(2, 8'h00);
    idle(3);
    chk("ch3_off", 32'h0000_0000, 32'({ch3_clk_out, ch3_inv_clk_out}));
    // chained mode: channel three follows channel two underflows only
    wr(1, 8'h80);
    wr(2, 8'h0c);
    idle(3);
    tog3 = 0;
    idle(100);
    chk("chain_stop", 32'h0000_0000, 32'(tog3));
    wr(1, 8'h84);
    idle(3);
    tog3 = 0;
    idle(100);
    chk("chain_run", 32'h0000_0001, 32'(tog3 > 0));
    test_done();
  end
endmodule
